// File: hw/vid_checker_regs.svh
`ifndef VID_CHECKER_REGS_SVH
`define VID_CHECKER_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CTRL_ADDR      8'h00
`define OFFSETS_ADDR   8'h04
`define FIXLIM1_ADDR   8'h08
`define FIXLIM2_ADDR   8'h0C
`define STATUS_A_ADDR  8'h10
`define STATUS_B_ADDR  8'h14
`define AVERAGE_ADDR   8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_MODE_LSB  0
`define CTRL_EN_BIT    2
`define ST_VID_LSB     0
`define ST_FIX_LSB     2
`define ST_GP_LSB      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST       3'h4
`define OFFSETS_RST    16'h1010
`define FIXLIM_RST     16'hFF00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ         20000000
`define PASS_TIME_MS   100
`define PASS_CYCLES    (`PASS_TIME_MS * (`CLK_HZ / 1000))
`define AVG_TIME_US    1500
`define AVG_CYCLES     (`AVG_TIME_US * (`CLK_HZ / 1000000))
`define AVG_SAMPLES    64
`define AVG_SHIFT      6
`define SKEW_TIME_NS   400
`define SKEW_CYCLES    ((`SKEW_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------------------------------
// voltage scale and code table
// ----------------------------------------------------------------
`define ADC_LSB_UV     6250
`define UPPER_CAP_UV   1587500
`define UPPER_CAP_CODE (`UPPER_CAP_UV / `ADC_LSB_UV)
`define DESC_BASE      8'hFE
`define ASC_BASE       8'h40
`define ASC_ALT_BASE   8'h80
`define LEG_OFF_CODE   7'h3F
`define EXT_OFF_CODE   7'h7F
`define NEW_OFF_CODE   7'h00

`endif

// File: hw/vid_checker_pkg.sv
package vid_checker_pkg;

  typedef enum logic [1:0] {
    legacy_regulator_mode,
    extended_regulator_mode,
    newer_regulator_mode,
    newer_alt_regulator_mode
  } vid_mode_t;

  typedef struct packed {
    logic [7:0] lower_off;
    logic [7:0] upper_off;
  } vid_offsets_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } fixed_limits_t;

  typedef struct packed {
    logic      enable;
    vid_mode_t mode;
  } ctrl_t;

endpackage : vid_checker_pkg

// File: hw/vid_avg.sv
`timescale 1ns/1ps
`include "vid_checker_regs.svh"

module vid_avg (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // synchronised code and mode
  input  wire logic [6:0]                  vid_code,
  input  vid_checker_pkg::vid_mode_t       mode,
  // window control
  input  wire logic                        start,
  input  wire logic                        tick,
  // result
  output logic [7:0]                       avg_r,
  output logic                             off_seen_r,
  output logic                             done_r
);

  localparam logic [3:0] SKEW = 4'(`SKEW_CYCLES);
  localparam logic [6:0] LAST = 7'(`AVG_SAMPLES - 1);

  logic [6:0]  cand_r;
  logic [6:0]  code_r;
  logic [3:0]  stab_r;
  logic [13:0] sum_r;
  logic [6:0]  cnt_r;
  logic        busy_r;

  // ----------------------------------------------------------------
  // skew filter: a code counts only once it has stood still
  // ----------------------------------------------------------------
  wire settled = (stab_r == SKEW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cand_r <= 7'h00;
      code_r <= 7'h00;
      stab_r <= 4'h0;
    end else begin
      if (vid_code != cand_r) begin
        cand_r <= vid_code;
        stab_r <= 4'h0;
      end else if (!settled) begin
        stab_r <= stab_r + 4'h1;
      end
      if (settled) begin
        code_r <= cand_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // code to reference voltage, in converter steps
  // ----------------------------------------------------------------
  wire       is_leg  = (mode == vid_checker_pkg::legacy_regulator_mode);
  wire       is_ext  = (mode == vid_checker_pkg::extended_regulator_mode);
  wire       is_new  = (mode == vid_checker_pkg::newer_regulator_mode);
  wire [6:0] code6   = {1'b0, code_r[5:0]};
  wire [7:0] ref_leg = 8'(`DESC_BASE - {code6, 1'b0});
  wire [7:0] ref_ext = 8'(`DESC_BASE - {1'b0, code_r});
  wire [7:0] ref_new = 8'(`ASC_BASE + {1'b0, code_r});
  wire [7:0] ref_alt = 8'(`ASC_ALT_BASE + {1'b0, code_r});
  wire [7:0] ref_v   = is_leg ? ref_leg :
                       is_ext ? ref_ext :
                       is_new ? ref_new : ref_alt;
  wire       is_off  = is_leg ? (code6 == `LEG_OFF_CODE) :
                       is_ext ? (code_r == `EXT_OFF_CODE) :
                                (code_r == `NEW_OFF_CODE);

  // ----------------------------------------------------------------
  // averaging over the window
  // ----------------------------------------------------------------
  wire [13:0] sum_nxt = sum_r + {6'h00, ref_v};
  wire        take    = busy_r && tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_r      <= 14'h0000;
      cnt_r      <= 7'h00;
      busy_r     <= 1'b0;
      avg_r      <= 8'h00;
      off_seen_r <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        sum_r      <= 14'h0000;
        cnt_r      <= 7'h00;
        busy_r     <= 1'b1;
        off_seen_r <= 1'b0;
      end else if (take) begin
        sum_r      <= sum_nxt;
        cnt_r      <= cnt_r + 7'h01;
        off_seen_r <= off_seen_r | is_off;
        if (cnt_r == LAST) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          avg_r  <= sum_nxt[13:`AVG_SHIFT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_code_settles: assert property (@(posedge aclk) disable iff (!aresetn)
    (code_r != $past(code_r)) |-> $past(stab_r) == SKEW)
    else $error("code accepted before settling");
  a_done_count: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r |-> $past(cnt_r) == LAST && $past(take))
    else $error("window closed at wrong sample count");

endmodule : vid_avg

// File: hw/vid_checker.sv
`timescale 1ns/1ps
`include "vid_checker_regs.svh"
// Contract
// - each processor rail checked against own code
// - tracking and fixed checks kept separate
// - four code modes, decoded per mode
// - skew glitches on code lines ignored
// - code voltage averaged over 1.5 ms
// - limits use average, not instantaneous code
// - limits are average plus/minus offsets
// - reading outside limits raises error
// - both checks run every 100 ms
// - off code in window skips tracking check
// - upper check skipped above 1.5875 V
// - seventh bit pins are inputs in legacy

module vid_checker #(
  parameter int unsigned PASS_CYCLES = `PASS_CYCLES,
  parameter int unsigned AVG_CYCLES  = `AVG_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // processor code pins
  input  wire logic [5:0]  cpu1_voltage_id_bits,
  input  wire logic        cpu1_seventh_voltage_id_bit,
  input  wire logic [5:0]  cpu2_voltage_id_bits,
  input  wire logic        cpu2_seventh_voltage_id_bit,
  // converter readings
  input  wire logic [7:0]  cpu1_core_voltage_input,
  input  wire logic [7:0]  cpu2_core_voltage_input,
  // error levels
  output logic             cpu1_vid_error,
  output logic             cpu2_vid_error
);

  localparam int unsigned SPACING = AVG_CYCLES / `AVG_SAMPLES;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  vid_checker_pkg::ctrl_t         ctrl_r;
  vid_checker_pkg::vid_offsets_t  offs_r;
  vid_checker_pkg::fixed_limits_t lim_r [2];

  logic [7:0]  aw_addr_r;
  logic        aw_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_hold_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  logic [20:0] pass_cnt_r;
  logic [15:0] space_cnt_r;
  logic        avg_active_r;
  logic        start_r;

  logic [1:0]  vid_err;
  logic [1:0]  fix_err;
  logic [1:0]  gp_in;
  logic [1:0]  done_w;
  logic [7:0]  avg_w [2];
  logic [6:0]  vid_pins [2];
  logic [7:0]  reading [2];

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    merge = {strb[1] ? new_v[15:8] : old_v[15:8],
             strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  wire aw_take    = awvalid && awready_r;
  wire w_take     = wvalid && wready_r;
  wire do_write   = aw_hold_r && w_hold_r && !bvalid_r;
  wire aw_hold_nx = (aw_hold_r || aw_take) && !do_write;
  wire w_hold_nx  = (w_hold_r || w_take) && !do_write;
  wire wr_ctrl    = do_write && (aw_addr_r == `CTRL_ADDR);
  wire wr_offs    = do_write && (aw_addr_r == `OFFSETS_ADDR);
  wire wr_lim1    = do_write && (aw_addr_r == `FIXLIM1_ADDR);
  wire wr_lim2    = do_write && (aw_addr_r == `FIXLIM2_ADDR);
  wire wr_stat    = do_write && (aw_addr_r == `STATUS_A_ADDR);
  wire wr_ro      = do_write && ((aw_addr_r == `STATUS_B_ADDR) ||
                                 (aw_addr_r == `AVERAGE_ADDR));
  wire wr_hit     = wr_ctrl || wr_offs || wr_lim1 || wr_lim2 ||
                    wr_stat || wr_ro;
  wire [3:0] clr  = (wr_stat && w_strb_r[0]) ? w_data_r[3:0] : 4'h0;
  wire [15:0] ctrl_m = merge({13'h0000, ctrl_r}, w_data_r, w_strb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
    end else begin
      aw_hold_r <= aw_hold_nx;
      w_hold_r  <= w_hold_nx;
      awready_r <= !aw_hold_nx;
      wready_r  <= !w_hold_nx;
      if (aw_take) begin
        aw_addr_r <= awaddr;
      end
      if (w_take) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `CTRL_RST;
      offs_r   <= `OFFSETS_RST;
      lim_r[0] <= `FIXLIM_RST;
      lim_r[1] <= `FIXLIM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_m[2:0];
      end
      if (wr_offs) begin
        offs_r <= merge(offs_r, w_data_r, w_strb_r);
      end
      if (wr_lim1) begin
        lim_r[0] <= merge(lim_r[0], w_data_r, w_strb_r);
      end
      if (wr_lim2) begin
        lim_r[1] <= merge(lim_r[1], w_data_r, w_strb_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire        ar_take = arvalid && arready_r;
  wire [15:0] status  = {10'h000, gp_in, fix_err, vid_err};
  wire [15:0] rd_mux  =
    (araddr == `CTRL_ADDR)     ? {13'h0000, ctrl_r} :
    (araddr == `OFFSETS_ADDR)  ? offs_r :
    (araddr == `FIXLIM1_ADDR)  ? lim_r[0] :
    (araddr == `FIXLIM2_ADDR)  ? lim_r[1] :
    (araddr == `STATUS_A_ADDR) ? status :
    (araddr == `STATUS_B_ADDR) ? status :
    (araddr == `AVERAGE_ADDR)  ? {avg_w[1], avg_w[0]} : 16'h0000;
  wire rd_hit = (araddr == `CTRL_ADDR) || (araddr == `OFFSETS_ADDR) ||
                (araddr == `FIXLIM1_ADDR) || (araddr == `FIXLIM2_ADDR) ||
                (araddr == `STATUS_A_ADDR) || (araddr == `STATUS_B_ADDR) ||
                (araddr == `AVERAGE_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OK;
    end else begin
      arready_r <= !(ar_take || (rvalid_r && !rready));
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {16'h0000, rd_mux};
        rresp_r  <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pass timebase and sampling window
  // ----------------------------------------------------------------
  wire pass_wrap  = (pass_cnt_r == 21'(PASS_CYCLES - 1));
  wire space_wrap = (space_cnt_r == 16'(SPACING - 1));
  wire tick       = avg_active_r && space_wrap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pass_cnt_r   <= 21'h000000;
      space_cnt_r  <= 16'h0000;
      avg_active_r <= 1'b0;
      start_r      <= 1'b0;
    end else begin
      pass_cnt_r <= pass_wrap ? 21'h000000 : pass_cnt_r + 21'h000001;
      start_r    <= pass_wrap;
      if (start_r) begin
        avg_active_r <= 1'b1;
        space_cnt_r  <= 16'h0000;
      end else if (done_w[0]) begin
        avg_active_r <= 1'b0;
      end else if (avg_active_r) begin
        space_cnt_r <= space_wrap ? 16'h0000 : space_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-processor checker
  // ----------------------------------------------------------------
  assign vid_pins[0] = {cpu1_seventh_voltage_id_bit, cpu1_voltage_id_bits};
  assign vid_pins[1] = {cpu2_seventh_voltage_id_bit, cpu2_voltage_id_bits};
  assign reading[0]  = cpu1_core_voltage_input;
  assign reading[1]  = cpu2_core_voltage_input;

  for (genvar i = 0; i < 2; i++) begin : g_cpu
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic       off_seen;
    logic       vid_err_r;
    logic       fix_err_r;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_r <= 7'h00;
        sync2_r <= 7'h00;
      end else begin
        sync1_r <= vid_pins[i];
        sync2_r <= sync1_r;
      end
    end

    vid_avg u_avg (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .vid_code   (sync2_r),
      .mode       (ctrl_r.mode),
      .start      (start_r),
      .tick       (tick),
      .avg_r      (avg_w[i]),
      .off_seen_r (off_seen),
      .done_r     (done_w[i])
    );

    wire       legacy  = (ctrl_r.mode ==
                          vid_checker_pkg::legacy_regulator_mode);
    wire [8:0] up_sum  = {1'b0, avg_w[i]} + {1'b0, offs_r.upper_off};
    wire       up_skip = (up_sum > 9'(`UPPER_CAP_CODE));
    wire       lo_ok   = (avg_w[i] >= offs_r.lower_off);
    wire [7:0] lo_lim  = avg_w[i] - offs_r.lower_off;
    wire       above   = !up_skip && ({1'b0, reading[i]} > up_sum);
    wire       below   = lo_ok && (reading[i] < lo_lim);
    wire       vid_hit = done_w[i] && ctrl_r.enable && !off_seen &&
                         (above || below);
    wire       fix_hit = done_w[i] && ((reading[i] > lim_r[i].high) ||
                                       (reading[i] < lim_r[i].low));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        vid_err_r <= 1'b0;
        fix_err_r <= 1'b0;
      end else begin
        vid_err_r <= vid_hit || (vid_err_r && !clr[i]);
        fix_err_r <= fix_hit || (fix_err_r && !clr[2+i]);
      end
    end

    assign vid_err[i] = vid_err_r;
    assign fix_err[i] = fix_err_r;
    assign gp_in[i]   = legacy && sync2_r[6];

    a_vid_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (done_w[i] && ctrl_r.enable && !off_seen && below)
      |=> vid_err_r)
      else $error("tracking error not raised below limit");
    a_off_skip: assert property (@(posedge aclk) disable iff (!aresetn)
      (done_w[i] && off_seen && !vid_err_r) |=> !vid_err_r)
      else $error("tracking error raised with off code in window");
    a_upper_cap: assert property (@(posedge aclk) disable iff (!aresetn)
      (done_w[i] && up_skip && !below && !vid_err_r)
      |=> !vid_err_r)
      else $error("upper check ran above cap");
    a_fixed_sep: assert property (@(posedge aclk) disable iff (!aresetn)
      fix_hit |=> fix_err_r ##0 (vid_err_r == $past(vid_hit) ||
                                 $past(vid_err_r)))
      else $error("fixed error not latched on its own");
    a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      (vid_hit && clr[i]) |=> vid_err_r)
      else $error("clear beat a new tracking error");
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready        = awready_r;
  assign wready         = wready_r;
  assign bvalid         = bvalid_r;
  assign bresp          = bresp_r;
  assign arready        = arready_r;
  assign rvalid         = rvalid_r;
  assign rdata          = rdata_r;
  assign rresp          = rresp_r;
  assign cpu1_vid_error = g_cpu[0].vid_err_r;
  assign cpu2_vid_error = g_cpu[1].vid_err_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pass_period: assert property (@(posedge aclk) disable iff (!aresetn)
    start_r |-> $past(pass_cnt_r) == 21'(PASS_CYCLES - 1))
    else $error("pass started off the timebase");
  a_tick_window: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |-> avg_active_r && !start_r)
    else $error("sample taken outside window");
  a_b_after_both: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bvalid_r) |-> $past(aw_hold_r && w_hold_r))
    else $error("write answered before address and data");
  a_r_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_r && !rready) |=> rvalid_r && $stable(rdata_r))
    else $error("read answer dropped before taken");

endmodule : vid_checker

// File: dv/cpu_vr_model.sv
`timescale 1ns/1ps
module cpu_vr_model #(
  parameter logic [6:0] INIT = 7'h00,
  parameter int         STEP = 100
) (
  // clock
  input  wire logic       aclk,
  // bench control
  input  wire logic [6:0] target,
  input  wire logic       glitch,
  input  wire logic [7:0] rail,
  // pins toward the checker
  output logic [5:0]      vid_bits,
  output logic            seventh,
  output logic [7:0]      core
);
  logic [6:0] cur_r = INIT;
  int         gap_r = 0;
  int         ph_r  = 0;

  // code walks one lsb at a time, never faster than STEP cycles
  always @(posedge aclk) begin
    gap_r <= (gap_r < STEP) ? gap_r + 1 : gap_r;
    ph_r  <= (ph_r + 1) % 16;
    if (gap_r >= STEP && cur_r != target) begin
      cur_r <= (cur_r < target) ? cur_r + 7'h01 : cur_r - 7'h01;
      gap_r <= 0;
    end
  end

  // skew burst: three cycles of an off pattern every sixteen
  assign {seventh, vid_bits} = (glitch && ph_r < 3) ? 7'h7F : cur_r;
  assign core = rail;
endmodule : cpu_vr_model

// File: dv/tb.sv
`timescale 1ns/1ps
`include "vid_checker_regs.svh"
module tb;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hF;
  logic [6:0]  t1      = 7'h50;
  logic [6:0]  t2      = 7'h12;
  logic        g1      = 1'b0;
  logic [7:0]  r1      = 8'hDE;
  logic [7:0]  r2      = 8'hDA;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  v1, v2;
  logic        s1, s2, e1, e2;
  logic [7:0]  c1, c2;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #25 aclk = ~aclk;

  vid_checker #(.PASS_CYCLES(400), .AVG_CYCLES(128)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .cpu1_voltage_id_bits(v1), .cpu1_seventh_voltage_id_bit(s1),
    .cpu2_voltage_id_bits(v2), .cpu2_seventh_voltage_id_bit(s2),
    .cpu1_core_voltage_input(c1), .cpu2_core_voltage_input(c2),
    .cpu1_vid_error(e1), .cpu2_vid_error(e2));

  cpu_vr_model #(.INIT(7'h50)) cpu1 (.aclk, .target(t1), .glitch(g1),
    .rail(r1), .vid_bits(v1), .seventh(s1), .core(c1));
  cpu_vr_model #(.INIT(7'h12)) cpu2 (.aclk, .target(t2), .glitch(1'b0),
    .rail(r2), .vid_bits(v2), .seventh(s2), .core(c2));

  task wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      wrap_up;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      fails++;
    end
  endtask : chk

  // waits as long as the slave needs; only the cycle ceiling ends a hang
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : rd

  // a full pass with the new setup lands after the status clear
  // one edge first so that targets set just before are already visible;
  // the second wait spans a whole period plus one window
  task settle;
    int n;
    n = 0;
    @(posedge aclk);
    while (({s1, v1} !== t1 || {s2, v2} !== t2) && n < 8000) begin
      @(posedge aclk);
      n++;
    end
    repeat (420) @(posedge aclk);
    wr(`STATUS_A_ADDR, 32'h0000000F, 2'h0);
    repeat (560) @(posedge aclk);
  endtask : settle

  task pass_chk(input logic [7:0] a, input logic [7:0] b,
                input logic [31:0] st);
    r1 <= a;
    r2 <= b;
    settle;
    chk({30'h0, e2, e1}, {30'h0, st[1:0]});
    rd(`STATUS_A_ADDR, st, 2'h0);
    rd(`STATUS_B_ADDR, st, 2'h0);
  endtask : pass_chk

  function automatic logic [7:0] ref_v(input int m, input logic [6:0] c);
    case (m)
      0: ref_v = `DESC_BASE - {1'b0, c[5:0], 1'b0};
      1: ref_v = `DESC_BASE - {1'b0, c};
      2: ref_v = `ASC_BASE + {1'b0, c};
      default: ref_v = `ASC_ALT_BASE + {1'b0, c};
    endcase
  endfunction : ref_v

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CTRL_ADDR, 32'h4, 2'h0);
    rd(`OFFSETS_ADDR, 32'h1010, 2'h0);
    rd(`FIXLIM1_ADDR, 32'hFF00, 2'h0);
    rd(`FIXLIM2_ADDR, 32'hFF00, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'h0, 2'h2);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(`CTRL_ADDR, 32'(4 + m), 2'h0);
      settle;
      rd(`AVERAGE_ADDR, {16'h0, ref_v(m, t2), ref_v(m, t1)}, 2'h0);
    end
    wr(`CTRL_ADDR, 32'h4, 2'h0);
    $display("test modes done");
    pass_chk(8'hEF, 8'hEA, 32'h11);
    pass_chk(8'hCE, 8'hC9, 32'h12);
    wr(`FIXLIM1_ADDR, 32'hC000, 2'h0);
    pass_chk(8'hDE, 8'hDA, 32'h14);
    wr(`FIXLIM1_ADDR, 32'hFF00, 2'h0);
    $display("test limits done");
    g1 <= 1'b1;
    pass_chk(8'hEF, 8'hDA, 32'h11);
    g1 <= 1'b0;
    t2 <= 7'h3F;
    pass_chk(8'hDE, 8'h00, 32'h10);
    $display("test skew and off code done");
    wr(`CTRL_ADDR, 32'h0, 2'h0);
    pass_chk(8'hEF, 8'h00, 32'h10);
    $display("test tracking disabled done");
    wr(`OFFSETS_ADDR, 32'h8050, 2'h0);
    wr(`CTRL_ADDR, 32'h5, 2'h0);
    pass_chk(8'hFF, 8'hFF, 32'h01);
    $display("test upper cap done");
    wrap_up;
  end
endmodule : tb
